// >>> dv/core_model.sv
// Core model: running counter, boundary handshake, return pulses
module core_model (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic slow, // Stay mid-instruction
	input wire logic ret_cmd, // Leave routine
	input wire logic vector_load, // Routine entry
	input wire logic [15:0] vector_addr, // Entry address
	output logic [15:0] pc_current, // Counter
	output logic core_irq_ready, // At boundary
	output logic reti_exec // Return done
);
	timeunit 1ns;
	timeprecision 1ps;
	// ========================================
	// Counter moves every cycle so a stale push value shows up
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pc_current <= 16'h0100;
			core_irq_ready <= 1'b0;
			reti_exec <= 1'b0;
		end else begin
			pc_current <= vector_load ? vector_addr
				: pc_current + 16'h0001;
			core_irq_ready <= !slow;
			reti_exec <= ret_cmd;
		end
	end
endmodule

// >>> dv/irq_ctrl_props.sv
// Checker: port properties of the interrupt controller
module irq_ctrl_props (
	input wire logic clk_sys, // Clock
	input wire logic rst, // Reset
	input wire logic [7:0] sfr_addr, // Address
	input wire logic sfr_wr, // Byte write
	input wire logic [7:0] sfr_wdata, // Data
	input wire logic sfr_bit_wr, // Bit write
	input wire logic [2:0] sfr_bit_sel, // Bit index
	input wire logic sfr_bit_val, // Bit value
	input wire logic [7:0] sfr_rdata, // Read data
	input wire logic [15:0] pc_current, // Counter
	input wire logic reti_exec, // Return
	input wire logic push_valid, // Push
	input wire logic [15:0] push_pc, // Pushed
	input wire logic vector_load, // Load
	input wire logic [15:0] vector_addr, // Vector
	input wire logic [1:0] in_service // Levels
);
	timeunit 1ns;
	timeprecision 1ps;
	import irq_ctrl_pkg::*;
	logic gate_reg;
	logic [4:0] shut_reg;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// ========================================
	// Gate shadow; saturating count of cycles with the gate shut
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			gate_reg <= 1'b0;
			shut_reg <= 5'h00;
		end else begin
			if (sfr_wr && sfr_addr == ENABLE_PRIMARY_ADDR)
				gate_reg <= sfr_wdata[7];
			else if (sfr_bit_wr && sfr_addr == ENABLE_PRIMARY_ADDR
				&& sfr_bit_sel == 3'h7)
				gate_reg <= sfr_bit_val;
			if (gate_reg)
				shut_reg <= 5'h00;
			else if (shut_reg != 5'h1F)
				shut_reg <= shut_reg + 5'h01;
		end
	end
	// ========================================
	// Entry sequence, nesting and register map
	push_order_a: assert property (push_valid |=> vector_load)
		else $error("no load after push");
	pc_saved_a: assert property (
		push_valid |-> push_pc == $past(pc_current))
		else $error("pushed counter wrong");
	vector_legal_a: assert property (
		vector_load |-> vector_addr inside {16'h0003, 16'h000B, 16'h0013,
		16'h001B, 16'h0023, 16'h002B, 16'h0033, 16'h003B, 16'h0043,
		16'h0053, 16'h005B}) else $error("vector off table");
	same_level_a: assert property (
		push_valid |-> !$past(in_service[1])) else $error("high nested");
	low_nested_a: assert property (
		push_valid && $past(in_service[0]) && !$past(reti_exec)
		|-> in_service == 2'b11)
		else $error("low routine preempted wrongly");
	level_set_a: assert property (
		$rose(in_service[0]) || $rose(in_service[1]) |-> push_valid)
		else $error("level set without push");
	reti_inner_a: assert property (
		reti_exec && in_service[1] |=> !in_service[1]
		&& $stable(in_service[0])) else $error("return cleared wrong level");
	gate_shut_a: assert property (
		shut_reg >= 5'h10 |-> !push_valid) else $error("entry with gate shut");
	reserved_zero_a: assert property (
		(sfr_addr == PRIORITY_PRIMARY_ADDR |-> !sfr_rdata[7]) and
		(sfr_addr == SECONDARY_ADDR |-> (sfr_rdata & 8'h88) == 8'h00))
		else $error("reserved bit set");
	byte_write_a: assert property (
		sfr_wr && sfr_addr == ENABLE_PRIMARY_ADDR ##1
		sfr_addr == ENABLE_PRIMARY_ADDR |-> sfr_rdata == $past(sfr_wdata))
		else $error("enable write lost");
	cover property (in_service == 2'b11);
	cover property (reti_exec && in_service[0]);
	cover property (vector_load && vector_addr == 16'h002B);
endmodule
bind irq_ctrl irq_ctrl_props u_irq_ctrl_props (.clk_sys, .rst, .sfr_addr,
	.sfr_wr, .sfr_wdata, .sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata,
	.pc_current, .reti_exec, .push_valid, .push_pc, .vector_load,
	.vector_addr, .in_service);

// >>> dv/tb_top.sv
// Testbench: registers, arbitration, nesting and vectors
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import irq_ctrl_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic sfr_wr = 1'b0;
	logic sfr_bit_wr = 1'b0;
	logic sfr_bit_val = 1'b0;
	logic ret_cmd = 1'b0;
	logic slow = 1'b0;
	logic [2:0] sfr_bit_sel = 3'h0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic [13:0] req = 14'h0000;
	logic [7:0] sfr_rdata;
	logic sfr_hit, core_irq_ready, reti_exec, push_valid, vector_load;
	logic [15:0] pc_current, push_pc, vector_addr;
	logic [1:0] in_service;
	logic [17:0] got;
	logic [31:0] ra, rb;
	integer seed = 32'h84CF;
	int fails = 0;
	int check_count = 0;
	// 50 MHz core clock
	always #10 clk_sys = ~clk_sys;
	// Core stalls two cycles in eight
	always @(negedge clk_sys) slow = pc_current[2:1] == 2'b11;
	irq_ctrl u_irq_ctrl (.clk_sys, .rst, .sfr_addr, .sfr_wr, .sfr_wdata,
		.sfr_bit_wr, .sfr_bit_sel, .sfr_bit_val, .sfr_rdata, .sfr_hit,
		.pc_current, .core_irq_ready, .reti_exec, .push_valid, .push_pc,
		.vector_load, .vector_addr, .in_service,
		.supply_monitor_request(req[0]), .watchdog_request(req[1]),
		.ext0_request(req[2]), .converter_request(req[3]),
		.timer0_overflow_flag(req[4]), .ext1_request(req[5]),
		.timer1_overflow_flag(req[6]), .two_wire_request(req[7]),
		.sync_serial_request(req[8]), .uart_receive_flag(req[9]),
		.uart_transmit_flag(req[10]), .timer2_overflow_flag(req[11]),
		.timer2_external_flag(req[12]), .interval_counter_request(req[13]));
	core_model u_core_model (.clk_sys, .rst, .slow, .ret_cmd, .vector_load,
		.vector_addr, .pc_current, .core_irq_ready, .reti_exec);
	// Predicted entry {high, low, vector}; zero when nothing is eligible
	function automatic logic [17:0] winner(input logic [13:0] r,
		input logic [7:0] ie, input logic [7:0] ip, input logic [7:0] sec);
		logic [10:0] q, pr;
		logic [15:0] vt [11] = '{16'h0043, 16'h005B, 16'h0003, 16'h0033,
			16'h000B, 16'h0013, 16'h001B, 16'h003B, 16'h0023, 16'h002B,
			16'h0053};
		winner = 18'h00000;
		q = {r[13], r[12] | r[11], r[10] | r[9], r[8] | r[7], r[6:0]};
		q = q & {sec[2], ie[5:4], sec[0], ie[3:1], ie[6], ie[0], 1'b1, sec[1]}
			& {11{ie[7]}};
		pr = q & {sec[6], ip[5:4], sec[4], ip[3:1], ip[6], ip[0], 1'b0, sec[5]};
		if (pr != 11'h000)
			q = pr;
		for (int i = 10; i >= 0; i--)
			if (q[i])
				winner = {pr != 11'h000, pr == 11'h000, vt[i]};
	endfunction
	// Compare and count
	task automatic check(input logic [17:0] seen, input logic [17:0] exp);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Byte write, or bit write with value in d[7] and index in d[2:0]
	task automatic put(input logic b, input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_bit_sel = d[2:0];
		sfr_bit_val = d[7];
		sfr_wr = !b;
		sfr_bit_wr = b;
		@(negedge clk_sys);
		sfr_wr = 1'b0;
		sfr_bit_wr = 1'b0;
	endtask
	// Reads are combinational, so look once the address settles
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge clk_sys);
		sfr_addr = a;
		#1 check({10'h000, sfr_rdata}, {10'h000, exp});
	endtask
	// Bounded wait for an entry; zero means none came
	task automatic await();
		got = 18'h00000;
		for (int n = 0; n < 60 && got == 18'h00000; n++) begin
			@(negedge clk_sys);
			if (vector_load === 1'b1)
				got = {in_service, vector_addr};
		end
	endtask
	// Let the request latch drain first, or a dropped flag re-enters
	task automatic leave();
		repeat (16) @(negedge clk_sys);
		ret_cmd = 1'b1;
		@(negedge clk_sys);
		ret_cmd = 1'b0;
		repeat (2) @(negedge clk_sys);
	endtask
	// One case: program, raise, compare the entry, clear, return
	task automatic run(input logic [13:0] r, input logic [7:0] ie,
		input logic [7:0] ip, input logic [7:0] sec);
		put(1'b0, ENABLE_PRIMARY_ADDR, ie);
		put(1'b0, PRIORITY_PRIMARY_ADDR, ip);
		put(1'b0, SECONDARY_ADDR, sec & 8'h77);
		rd(SECONDARY_ADDR, sec & 8'h77);
		req = r;
		await();
		req = 14'h0000;
		check(got, winner(r, ie, ip, sec));
		if (got !== 18'h00000)
			leave();
		check({16'h0000, in_service}, 18'h00000);
	endtask
	// Report counts and the verdict, then stop
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (10) @(negedge clk_sys);
		rst = 1'b0;
		rd(ENABLE_PRIMARY_ADDR, 8'h00);
		rd(PRIORITY_PRIMARY_ADDR, 8'h00);
		rd(SECONDARY_ADDR, SECONDARY_RESET);
		put(1'b0, 8'hA0, 8'hFF);
		rd(8'hA0, 8'h00);
		check({17'h00000, sfr_hit}, 18'h00000);
		put(1'b1, ENABLE_PRIMARY_ADDR, 8'h87);
		put(1'b1, ENABLE_PRIMARY_ADDR, 8'h80);
		rd(ENABLE_PRIMARY_ADDR, 8'h81);
		put(1'b1, PRIORITY_PRIMARY_ADDR, 8'h87);
		rd(PRIORITY_PRIMARY_ADDR, 8'h00);
		put(1'b1, SECONDARY_ADDR, 8'h86);
		rd(SECONDARY_ADDR, 8'h40);
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 14; i++)
				run(14'h0001 << i, 8'hFF, p ? 8'h7F : 8'h00,
					p ? 8'h77 : 8'h07);
		run(14'h3FFF, 8'hFF, 8'h00, 8'h07);
		run(14'h3FFF, 8'hFF, 8'h20, 8'h07);
		run(14'h3FFF, 8'h7F, 8'h7F, 8'h77);
		repeat (40) begin
			ra = $random(seed);
			rb = $random(seed);
			run(ra[13:0], ra[31:24], rb[7:0], rb[15:8]);
		end
		// Random runs leave the enables scattered; open all primary enables for nesting
		put(1'b0, ENABLE_PRIMARY_ADDR, 8'hFF);
		put(1'b0, PRIORITY_PRIMARY_ADDR, 8'h02);
		req = 14'h0004;
		await();
		check(got, {2'b01, 16'h0003});
		req = 14'h0020;
		await();
		check(got, 18'h00000);
		req = 14'h0030;
		await();
		check(got, {2'b11, 16'h000B});
		req = 14'h0020;
		leave();
		check({16'h0000, in_service}, 18'h00001);
		leave();
		await();
		check(got, {2'b01, 16'h0013});
		req = 14'h0000;
		leave();
		conclude();
	end
	// Watchdog sized well above the expected run length
	initial begin
		repeat (40000) @(posedge clk_sys);
		fails++;
		conclude();
	end
endmodule

// >>> logic/irq_ctrl.sv
// Two-level vectored interrupt controller for an 8051-style core
//
// How it works
// - Global gate bit 7 of the primary enable register blocks all.
// - Primary enable bits 6..0 enable converter..external 0.
// - Primary priority bits 6..0 select high (1) or low, bit 7 reserved.
// - Secondary bits 2..0 enable interval counter, supply, serial.
// - Secondary bits 6..4 give their priorities, bit 7 reserved.
// - Primary registers reset to zero and accept single-bit writes.
// - A high-priority request preempts a low-level service routine.
// - When both levels are pending the high level is granted first.
// - No request preempts a routine running at its own level.
// - Within a level sources are polled in a fixed order.
// - On acceptance the program counter is pushed first.
// - Then the source's fixed vector is loaded into the counter.
module irq_ctrl (
	input wire logic clk_sys, // Core clock
	input wire logic rst, // Asynchronous reset, active high
	// Core special-function register port
	input wire logic [7:0] sfr_addr, // Register address
	input wire logic sfr_wr, // Byte write strobe
	input wire logic [7:0] sfr_wdata, // Byte write data
	input wire logic sfr_bit_wr, // Single-bit write strobe
	input wire logic [2:0] sfr_bit_sel, // Bit index for bit write
	input wire logic sfr_bit_val, // Bit value for bit write
	output logic [7:0] sfr_rdata, // Read data, combinational
	output logic sfr_hit, // Address belongs to this block
	// Core sequencing
	input wire logic [15:0] pc_current, // Program counter to save
	input wire logic core_irq_ready, // Core at instruction boundary
	input wire logic reti_exec, // Return-from-interrupt executed
	output logic push_valid, // Push request pulse
	output logic [15:0] push_pc, // Counter value to push
	output logic vector_load, // Vector load pulse
	output logic [15:0] vector_addr, // Vector address
	output logic [1:0] in_service, // Bit 1 high level, bit 0 low
	// Peripheral request flags
	input wire logic supply_monitor_request, // Supply monitor
	input wire logic watchdog_request, // Watchdog
	input wire logic ext0_request, // External 0
	input wire logic converter_request, // Converter
	input wire logic timer0_overflow_flag, // Timer 0
	input wire logic ext1_request, // External 1
	input wire logic timer1_overflow_flag, // Timer 1
	input wire logic two_wire_request, // Two-wire serial
	input wire logic sync_serial_request, // Synchronous serial
	input wire logic uart_receive_flag, // UART receive
	input wire logic uart_transmit_flag, // UART transmit
	input wire logic timer2_overflow_flag, // Timer 2 overflow
	input wire logic timer2_external_flag, // Timer 2 external
	input wire logic interval_counter_request // Interval counter
);
	import irq_ctrl_pkg::*;

	// All state in one record; cur_next is its value for the next edge
	typedef struct packed {
		logic [7:0] enable_primary;
		logic [7:0] priority_primary;
		logic [7:0] secondary;
		logic [MC_COUNT_WIDTH-1:0] mc_count;
		logic [NUM_SOURCES-1:0] sampled;
		logic hi_active;
		logic lo_active;
		ack_state_type state;
		logic [SRC_WIDTH-1:0] source;
		logic push_valid;
		logic [15:0] push_pc;
		logic vector_load;
		logic [15:0] vector_addr;
	} state_type;

	state_type cur_reg, cur_next;

	// ==============================================
	// Bit write helper shared by all three registers
	// A bit write keeps the other seven bits, as a read-modify-write would
	function automatic logic [7:0] bit_update(input logic [7:0] value,
		input logic [2:0] sel, input logic bitval);
		logic [7:0] res;
		res = value;
		res[sel] = bitval;
		return res;
	endfunction

	// Address match shared by byte and bit writes
	function automatic logic is_write(input logic [7:0] addr,
		input logic [7:0] target);
		return addr == target;
	endfunction

	// ==============================================
	// Per-source enable and priority in polling order
	logic [NUM_SOURCES-1:0] raw_request;
	logic [NUM_SOURCES-1:0] src_enable;
	logic [NUM_SOURCES-1:0] src_high;
	logic gate;

	// Paired flags share one request line
	// The routine must poll both flags to learn which one fired
	always_comb begin
		raw_request = '0;
		raw_request[SRC_PSM] = supply_monitor_request;
		raw_request[SRC_WDOG] = watchdog_request;
		raw_request[SRC_EXT0] = ext0_request;
		raw_request[SRC_CONV] = converter_request;
		raw_request[SRC_TMR0] = timer0_overflow_flag;
		raw_request[SRC_EXT1] = ext1_request;
		raw_request[SRC_TMR1] = timer1_overflow_flag;
		raw_request[SRC_SER] = two_wire_request | sync_serial_request;
		raw_request[SRC_UART] = uart_receive_flag | uart_transmit_flag;
		raw_request[SRC_TMR2] = timer2_overflow_flag | timer2_external_flag;
		raw_request[SRC_TIC] = interval_counter_request;
	end

	// ==============================================
	// Rank-order view of one enable or priority set. Both primaries share
	// one bit layout, so a single decode serves both and cannot drift.
	// The watchdog slot stays zero: it has no bit in either register.
	function automatic logic [NUM_SOURCES-1:0] rank_view(
		input logic [7:0] primary, input logic tic_bit,
		input logic psm_bit, input logic ser_bit);
		logic [NUM_SOURCES-1:0] res;
		res = '0;
		res[SRC_EXT0] = primary[EXT0_BIT];
		res[SRC_TMR0] = primary[TMR0_BIT];
		res[SRC_EXT1] = primary[EXT1_BIT];
		res[SRC_TMR1] = primary[TMR1_BIT];
		res[SRC_UART] = primary[UART_BIT];
		res[SRC_TMR2] = primary[TMR2_BIT];
		res[SRC_CONV] = primary[CONV_BIT];
		res[SRC_TIC] = tic_bit;
		res[SRC_PSM] = psm_bit;
		res[SRC_SER] = ser_bit;
		return res;
	endfunction

	// Watchdog has no enable bit and no priority bit: on whenever the global gate is open, low level
	always_comb begin
		src_enable = rank_view(cur_reg.enable_primary,
			cur_reg.secondary[SEC_TIC_EN_BIT],
			cur_reg.secondary[SEC_PSM_EN_BIT],
			cur_reg.secondary[SEC_SER_EN_BIT]);
		src_enable[SRC_WDOG] = 1'b1;
		src_high = rank_view(cur_reg.priority_primary,
			cur_reg.secondary[SEC_TIC_PRI_BIT],
			cur_reg.secondary[SEC_PSM_PRI_BIT],
			cur_reg.secondary[SEC_SER_PRI_BIT]);
	end

	// Gate is applied where requests are sampled, so shutting it stops
	// new entries within one machine cycle
	assign gate = cur_reg.enable_primary[GLOBAL_GATE_BIT];

	// ==============================================
	// Level split and fixed-order selection
	logic [NUM_SOURCES-1:0] hi_req, lo_req, sel_req;
	logic hi_any, lo_any, sel_found;
	logic [SRC_WIDTH-1:0] sel_rank;
	logic hi_ok, lo_ok, grant_high;

	assign hi_req = cur_reg.sampled & src_high;
	assign lo_req = cur_reg.sampled & ~src_high;
	assign hi_any = |hi_req;
	assign lo_any = |lo_req;
	// High level may enter over a low routine, never over its own level
	assign hi_ok = hi_any && !cur_reg.hi_active;
	assign lo_ok = lo_any && !cur_reg.hi_active && !cur_reg.lo_active;
	assign grant_high = hi_ok;
	assign sel_req = grant_high ? hi_req : lo_req;

	// Rank 0 wins inside whichever level was allowed to enter
	irq_select #(
		.N(NUM_SOURCES)
	) u_select (
		.request(sel_req),
		.found(sel_found),
		.rank(sel_rank)
	);

	// ==============================================
	// Read side: reserved bits come back as zero
	// Reads have no side effects, so the core may poll freely
	always_comb begin
		sfr_hit = 1'b1;
		sfr_rdata = 8'h00;
		case (sfr_addr)
			ENABLE_PRIMARY_ADDR: sfr_rdata = cur_reg.enable_primary;
			PRIORITY_PRIMARY_ADDR: sfr_rdata = cur_reg.priority_primary;
			SECONDARY_ADDR: sfr_rdata = cur_reg.secondary;
			default: sfr_hit = 1'b0;
		endcase
	end

	// ==============================================
	// Next-state logic
	always_comb begin
		cur_next = cur_reg;
		cur_next.push_valid = 1'b0;
		cur_next.vector_load = 1'b0;

		// Byte and single-bit writes; bit write makes both primaries bit
		// addressable, the secondary accepts it too for symmetry
		if (sfr_wr && is_write(sfr_addr, ENABLE_PRIMARY_ADDR)) begin
			cur_next.enable_primary = sfr_wdata;
		end else if (sfr_bit_wr && is_write(sfr_addr, ENABLE_PRIMARY_ADDR)) begin
			cur_next.enable_primary = bit_update(cur_reg.enable_primary,
				sfr_bit_sel, sfr_bit_val);
		end
		if (sfr_wr && is_write(sfr_addr, PRIORITY_PRIMARY_ADDR)) begin
			cur_next.priority_primary = sfr_wdata & PRIORITY_WRITE_MASK;
		end else if (sfr_bit_wr && is_write(sfr_addr, PRIORITY_PRIMARY_ADDR)) begin
			cur_next.priority_primary = bit_update(cur_reg.priority_primary,
				sfr_bit_sel, sfr_bit_val) & PRIORITY_WRITE_MASK;
		end
		// Bit 3 is stored as zero so a careless write cannot misconfigure
		if (sfr_wr && is_write(sfr_addr, SECONDARY_ADDR)) begin
			cur_next.secondary = sfr_wdata & SECONDARY_WRITE_MASK;
		end else if (sfr_bit_wr && is_write(sfr_addr, SECONDARY_ADDR)) begin
			cur_next.secondary = bit_update(cur_reg.secondary,
				sfr_bit_sel, sfr_bit_val) & SECONDARY_WRITE_MASK;
		end

		// Machine-cycle divider; requests latch once per machine cycle.
		// Limitation: a flag shorter than a machine cycle may be missed,
		// so peripherals hold their flags until software clears them.
		if (cur_reg.mc_count == MC_COUNT_WIDTH'(CLOCKS_PER_MACHINE_CYCLE - 1)) begin
			cur_next.mc_count = '0;
			cur_next.sampled = raw_request & src_enable
				& {NUM_SOURCES{gate}};
		end else begin
			cur_next.mc_count = cur_reg.mc_count + 1'b1;
		end

		// Return clears the highest active level first
		// A return with neither level active has nothing to clear
		if (reti_exec) begin
			if (cur_reg.hi_active) begin
				cur_next.hi_active = 1'b0;
			end else begin
				cur_next.lo_active = 1'b0;
			end
		end

		// Acceptance sequence: push, then load vector
		// The next acceptance waits for idle, three cycles after the last,
		// so a push and a load never overlap
		case (cur_reg.state)
			ST_IDLE: begin
				if (core_irq_ready && sel_found && (hi_ok || lo_ok)) begin
					cur_next.source = sel_rank;
					cur_next.push_pc = pc_current;
					cur_next.push_valid = 1'b1;
					cur_next.state = ST_PUSH;
					if (grant_high) begin
						cur_next.hi_active = 1'b1;
					end else begin
						cur_next.lo_active = 1'b1;
					end
				end
			end
			ST_PUSH: begin
				// Vector comes from the rank held at acceptance, not the
				// live selection, which may already have moved on
				cur_next.vector_addr = VECTOR_TABLE[cur_reg.source];
				cur_next.vector_load = 1'b1;
				cur_next.state = ST_LOAD;
			end
			ST_LOAD: begin
				// One spare cycle before idle; the sampled flags refresh only at the machine-cycle boundary
				cur_next.state = ST_IDLE;
			end
			default: begin
				cur_next.state = ST_IDLE;
			end
		endcase
	end

	// ==============================================
	// State register
	// Reset clears both levels so a routine cut short by reset cannot
	// hold off later requests
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cur_reg <= '{enable_primary: ENABLE_PRIMARY_RESET,
				priority_primary: PRIORITY_PRIMARY_RESET,
				secondary: SECONDARY_RESET,
				state: ST_IDLE,
				default: '0};
		end else begin
			cur_reg <= cur_next;
		end
	end

	// Outputs come straight from the state register
	assign push_valid = cur_reg.push_valid;
	assign push_pc = cur_reg.push_pc;
	assign vector_load = cur_reg.vector_load;
	assign vector_addr = cur_reg.vector_addr;
	assign in_service = {cur_reg.hi_active, cur_reg.lo_active};
endmodule

// >>> logic/irq_ctrl_pkg.sv
// Package: register offsets, bit positions, source ranks and vectors
package irq_ctrl_pkg;

	// ==============================================
	// Register offsets (core special-function space)
	localparam logic [7:0] ENABLE_PRIMARY_ADDR = 8'hA8;
	localparam logic [7:0] PRIORITY_PRIMARY_ADDR = 8'hB8;
	localparam logic [7:0] SECONDARY_ADDR = 8'hA9; // No printed offset
	localparam logic [7:0] ENABLE_PRIMARY_RESET = 8'h00;
	localparam logic [7:0] PRIORITY_PRIMARY_RESET = 8'h00;
	localparam logic [7:0] SECONDARY_RESET = 8'h00;
	localparam logic [7:0] SECONDARY_WRITE_MASK = 8'h77; // Bits 7 and 3 zero
	localparam logic [7:0] PRIORITY_WRITE_MASK = 8'h7F; // Bit 7 reserved

	// ==============================================
	// Bit positions
	localparam int GLOBAL_GATE_BIT = 7;
	localparam int SEC_TIC_EN_BIT = 2;
	localparam int SEC_PSM_EN_BIT = 1;
	localparam int SEC_SER_EN_BIT = 0;
	localparam int SEC_TIC_PRI_BIT = 6;
	localparam int SEC_PSM_PRI_BIT = 5;
	localparam int SEC_SER_PRI_BIT = 4;
	localparam int BIT_INDEX_WIDTH = 3;
	// Source bits shared by the primary enable and priority registers
	localparam int EXT0_BIT = 0;
	localparam int TMR0_BIT = 1;
	localparam int EXT1_BIT = 2;
	localparam int TMR1_BIT = 3;
	localparam int UART_BIT = 4;
	localparam int TMR2_BIT = 5;
	localparam int CONV_BIT = 6;

	// ==============================================
	// Sources in polling order, rank 0 is polled first
	localparam int NUM_SOURCES = 11;
	localparam int SRC_WIDTH = 4;
	localparam logic [3:0] SRC_PSM = 4'h0;
	localparam logic [3:0] SRC_WDOG = 4'h1;
	localparam logic [3:0] SRC_EXT0 = 4'h2;
	localparam logic [3:0] SRC_CONV = 4'h3;
	localparam logic [3:0] SRC_TMR0 = 4'h4;
	localparam logic [3:0] SRC_EXT1 = 4'h5;
	localparam logic [3:0] SRC_TMR1 = 4'h6;
	localparam logic [3:0] SRC_SER = 4'h7;
	localparam logic [3:0] SRC_UART = 4'h8;
	localparam logic [3:0] SRC_TMR2 = 4'h9;
	localparam logic [3:0] SRC_TIC = 4'hA;

	// Vector addresses indexed by polling rank
	localparam logic [15:0] VECTOR_TABLE [NUM_SOURCES] = '{
		16'h0043, 16'h005B, 16'h0003, 16'h0033, 16'h000B, 16'h0013,
		16'h001B, 16'h003B, 16'h0023, 16'h002B, 16'h0053};

	// Machine cycle length in core clocks
	localparam int CLOCKS_PER_MACHINE_CYCLE = 12;
	localparam int MC_COUNT_WIDTH = 4;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_PUSH = 2'b01,
		ST_LOAD = 2'b10
	} ack_state_type;

endpackage

// >>> logic/irq_select.sv
// Fixed-order selector: lowest rank among the asserted requests wins
module irq_select #(
	parameter int N = irq_ctrl_pkg::NUM_SOURCES
) (
	input wire logic [N-1:0] request, // Candidate requests by rank
	output logic found, // Some request is asserted
	output logic [irq_ctrl_pkg::SRC_WIDTH-1:0] rank // Winning rank
);
	import irq_ctrl_pkg::*;

	// Scan from the lowest priority upward so rank 0 overrides the rest
	always_comb begin
		found = 1'b0;
		rank = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (request[i]) begin
				found = 1'b1;
				rank = SRC_WIDTH'(i);
			end
		end
	end
endmodule
